//--- design/sar_adc_cfg.svh
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// ==========================================================================
// Register byte offsets on the APB
// ==========================================================================
`define OFS_CHAN_RUN     8'h00
`define OFS_REF_PIN      8'h04
`define OFS_TIMING_FMT   8'h08
`define OFS_RESULT_UPPER 8'h0C
`define OFS_RESULT_LOWER 8'h10
`define OFS_DONE_FLAG    8'h14

// ==========================================================================
// Field positions
// ==========================================================================
`define BIT_MODULE_ON    0
`define BIT_GO           1
`define LSB_SELECTOR     2
`define MSB_SELECTOR     5
`define LSB_PIN_CFG      0
`define MSB_PIN_CFG      3
`define BIT_POS_REF      4
`define BIT_NEG_REF      5
`define LSB_CONV_CLK     0
`define MSB_CONV_CLK     2
`define LSB_ACQ          3
`define MSB_ACQ          5
`define BIT_JUSTIFY      7
`define BIT_DONE_FLAG    0

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_PIN_CFG_FUSE_SET   4'h0
`define RST_PIN_CFG_FUSE_CLEAR 4'h7
`define RST_SELECTOR           4'h0
`define RST_ACQ                3'h0
`define RST_CONV_CLK           3'h0

// ==========================================================================
// Timing
// ==========================================================================
`define CLOCK_PERIOD_NS   50
`define RC_PERIOD_NS      4000
`define RC_PERIOD_CLOCKS  (`RC_PERIOD_NS / `CLOCK_PERIOD_NS)
`define INSTR_CYCLE_CLOCKS 4
`define CONV_PERIODS      11
`define HOLDOFF_PERIODS   3
`define LAST_CHANNEL      4'hC
`define NUM_INPUTS        13

`endif

//--- design/sar_adc_pkg.sv
package sar_adc_pkg;

  // ========================================================================
  // Controller states
  // ========================================================================
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000, // Sampling the selected input
    ST_RC_DELAY = 3'b001, // One instruction cycle before RC clock starts
    ST_ACQUIRE  = 3'b010, // Programmed acquisition
    ST_CONVERT  = 3'b011, // Successive approximation
    ST_HOLDOFF  = 3'b100  // Recovery before next acquisition
  } state_t;

  // ========================================================================
  // APB request bundle from the master
  // ========================================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

//--- design/sar_adc_clkdiv.sv
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"

// ==========================================================================
// Conversion clock enable generator
// ==========================================================================
module sar_adc_clkdiv #(
  parameter int RC_DIV = `RC_PERIOD_CLOCKS
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic run_in, // Divider runs while high
  input wire logic osc_en_in, // System oscillator running
  input wire logic [2:0] sel_in, // Conversion clock select
  output logic tick_out // One pulse per conversion clock period
);

  logic [7:0] count; // Cycles within the current period
  logic [7:0] terminal; // Last count of a period
  logic rc_sel; // Internal RC source chosen

  // Period decode; RC stands in for the free-running RC oscillator
  always_comb begin
    rc_sel = 1'b0;
    unique case (sel_in)
      3'b000: terminal = 8'h01;
      3'b001: terminal = 8'h07;
      3'b010: terminal = 8'h1F;
      3'b100: terminal = 8'h03;
      3'b101: terminal = 8'h0F;
      3'b110: terminal = 8'h3F;
      default: begin
        terminal = 8'(RC_DIV - 1);
        rc_sel = 1'b1;
      end
    endcase
  end

  // Count; oscillator-derived clocks stop in sleep, RC does not
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (rc_sel || osc_en_in) begin
      if (count >= terminal) begin
        count <= 8'h00;
        tick_out <= 1'b1;
      end else begin
        count <= count + 8'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule

//--- design/sar_adc_control_unit.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"


module sar_adc_control_unit #(
  parameter bit LARGE_PACKAGE = 1'b1, // Thirteen inputs when set
  parameter int RC_DIV = `RC_PERIOD_CLOCKS // Clocks per RC period
) (
  input wire logic CLOCK_IN, // 20 MHz system clock
  input wire logic SYS_RST_IN, // Synchronous reset, active high
  input wire sar_adc_pkg::apb_req_t APB_REQ_IN, // APB request bundle
  output logic [31:0] APB_PRDATA_OUT, // APB read data
  output logic APB_PREADY_OUT, // APB ready
  output logic APB_PSLVERR_OUT, // APB error on unmapped address
  input wire logic PORT_ANALOG_FUSE_IN, // Port-analog fuse strap
  input wire logic SLEEP_IN, // Device in sleep, oscillator stopped
  input wire logic COMP_IN, // Comparator: held sample above trial
  output logic [9:0] DAC_CODE_OUT, // Trial code to the DAC
  output logic SAMPLE_OUT, // Sampling switch closed
  output logic CONVERTING_OUT, // Hold capacitor isolated, converting
  output logic [3:0] CHANNEL_OUT, // Input multiplexer select
  output logic CHANNEL_VALID_OUT, // Selector names a real input
  output logic [12:0] ANALOG_PINS_OUT, // Per-input analog mode
  output logic NEG_REF_EXT_OUT, // Negative reference from pin
  output logic POS_REF_EXT_OUT, // Positive reference from pin
  output logic MODULE_ON_OUT, // Converter powered
  output logic DONE_FLAG_OUT // Conversion done flag
);

  // ========================================================================
  // Declarations
  // ========================================================================
  sar_adc_pkg::state_t state; // Controller state
  sar_adc_pkg::state_t next_state; // Next controller state
  sar_adc_pkg::state_t launch_state; // Where a start goes
  logic module_on; // Module enable bit
  logic go; // Conversion status bit
  logic [3:0] selector; // Input selector
  logic neg_ref_select; // Negative reference source
  logic pos_ref_select; // Positive reference source
  logic [3:0] pin_config_field; // Analog/digital map code
  logic justify_select; // 1 right, 0 left
  logic [2:0] acquisition_field; // Acquisition time code
  logic [2:0] conv_clock_select; // Conversion clock code
  logic conv_done_flag; // Sticky done flag
  logic [7:0] result_upper; // Result high byte
  logic [7:0] result_lower; // Result low byte
  logic [9:0] sar; // Approximation register
  logic [9:0] next_sar; // Approximation after this decision
  logic [3:0] bit_idx; // Bit under trial
  logic [4:0] period_cnt; // Periods spent in current state
  logic [4:0] acq_periods; // Decoded acquisition periods
  logic [2:0] delay_cnt; // Clocks in RC start delay
  logic tick; // One conversion clock period elapsed
  logic fuse_s1, fuse_s2; // Fuse synchroniser
  logic comp_s1, comp_s2; // Comparator synchroniser
  logic sleep_s1, sleep_s2; // Sleep synchroniser
  logic rc_sel; // RC conversion clock chosen
  logic access; // APB access phase
  logic wr_en; // Write takes effect this edge
  logic go_set; // Accepted start request
  logic done_evt; // Last decision of a conversion
  logic flag_clr; // Software clears done flag
  logic addr_ok; // Address is mapped
  logic [31:0] rd_data; // Read mux
  logic [12:0] analog_map; // Decoded analog mask
  logic chan_ok; // Selector decodes to an input

  // ========================================================================
  // Synchronisers for asynchronous inputs
  // ========================================================================
  // Pins may change at any time; two flops each before use
  always_ff @(posedge CLOCK_IN) begin
    fuse_s1 <= PORT_ANALOG_FUSE_IN;
    fuse_s2 <= fuse_s1;
    comp_s1 <= COMP_IN;
    comp_s2 <= comp_s1;
    sleep_s1 <= SLEEP_IN;
    sleep_s2 <= sleep_s1;
  end

  // ========================================================================
  // APB decode
  // ========================================================================
  assign access = APB_REQ_IN.psel && APB_REQ_IN.penable;
  assign wr_en = access && APB_REQ_IN.pwrite && APB_PREADY_OUT;
  assign flag_clr = wr_en && (APB_REQ_IN.paddr == `OFS_DONE_FLAG) &&
                    APB_REQ_IN.pwdata[`BIT_DONE_FLAG];

  // Start only when on, idle or recovering, and not already pending
  assign go_set = wr_en && (APB_REQ_IN.paddr == `OFS_CHAN_RUN) &&
                  APB_REQ_IN.pwdata[`BIT_GO] && module_on && !go &&
                  (state == sar_adc_pkg::ST_IDLE || state == sar_adc_pkg::ST_HOLDOFF);

  always_comb begin
    unique case (APB_REQ_IN.paddr)
      `OFS_CHAN_RUN, `OFS_REF_PIN, `OFS_TIMING_FMT,
      `OFS_RESULT_UPPER, `OFS_RESULT_LOWER, `OFS_DONE_FLAG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read mux; unused upper bits fixed at zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (APB_REQ_IN.paddr)
      `OFS_CHAN_RUN: rd_data[7:0] = {2'b00, selector, go, module_on};
      `OFS_REF_PIN: rd_data[7:0] = {2'b00, neg_ref_select, pos_ref_select,
                                    pin_config_field};
      `OFS_TIMING_FMT: rd_data[7:0] = {justify_select, 1'b0, acquisition_field,
                                       conv_clock_select};
      `OFS_RESULT_UPPER: rd_data[7:0] = result_upper;
      `OFS_RESULT_LOWER: rd_data[7:0] = result_lower;
      `OFS_DONE_FLAG: rd_data[0] = conv_done_flag;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      APB_PREADY_OUT <= 1'b0;
      APB_PRDATA_OUT <= 32'h0000_0000;
      APB_PSLVERR_OUT <= 1'b0;
    end else if (access && !APB_PREADY_OUT) begin
      APB_PREADY_OUT <= 1'b1;
      APB_PRDATA_OUT <= APB_REQ_IN.pwrite ? 32'h0000_0000 : rd_data;
      APB_PSLVERR_OUT <= !addr_ok;
    end else begin
      APB_PREADY_OUT <= 1'b0;
      APB_PSLVERR_OUT <= 1'b0;
    end
  end

  // ========================================================================
  // Configuration registers
  // ========================================================================
  // Every device reset restores these; pin map follows the fuse
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      module_on <= 1'b0;
      selector <= `RST_SELECTOR;
      neg_ref_select <= 1'b0;
      pos_ref_select <= 1'b0;
      pin_config_field <= fuse_s2 ? `RST_PIN_CFG_FUSE_SET
                                  : `RST_PIN_CFG_FUSE_CLEAR;
      justify_select <= 1'b0;
      acquisition_field <= `RST_ACQ;
      conv_clock_select <= `RST_CONV_CLK;
    end else if (wr_en) begin
      unique case (APB_REQ_IN.paddr)
        `OFS_CHAN_RUN: begin
          module_on <= APB_REQ_IN.pwdata[`BIT_MODULE_ON];
          selector <= APB_REQ_IN.pwdata[`MSB_SELECTOR:`LSB_SELECTOR];
        end
        `OFS_REF_PIN: begin
          neg_ref_select <= APB_REQ_IN.pwdata[`BIT_NEG_REF];
          pos_ref_select <= APB_REQ_IN.pwdata[`BIT_POS_REF];
          pin_config_field <= APB_REQ_IN.pwdata[`MSB_PIN_CFG:`LSB_PIN_CFG];
        end
        `OFS_TIMING_FMT: begin
          justify_select <= APB_REQ_IN.pwdata[`BIT_JUSTIFY];
          acquisition_field <= APB_REQ_IN.pwdata[`MSB_ACQ:`LSB_ACQ];
          conv_clock_select <= APB_REQ_IN.pwdata[`MSB_CONV_CLK:`LSB_CONV_CLK];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Timing decode
  // ========================================================================
  always_comb begin
    unique case (acquisition_field)
      3'b111: acq_periods = 5'd20;
      3'b110: acq_periods = 5'd16;
      3'b101: acq_periods = 5'd12;
      3'b100: acq_periods = 5'd8;
      3'b011: acq_periods = 5'd6;
      3'b010: acq_periods = 5'd4;
      3'b001: acq_periods = 5'd2;
      3'b000: acq_periods = 5'd0;
    endcase
  end

  assign rc_sel = (conv_clock_select[1:0] == 2'b11);
  assign done_evt = (state == sar_adc_pkg::ST_CONVERT) && tick &&
                    (period_cnt == 5'(`CONV_PERIODS - 1));

  // Conversion clock; runs only once the timed states are reached
  sar_adc_clkdiv #(
    .RC_DIV(RC_DIV)
  ) u_clkdiv (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .run_in(state == sar_adc_pkg::ST_ACQUIRE || state == sar_adc_pkg::ST_CONVERT ||
            state == sar_adc_pkg::ST_HOLDOFF),
    .osc_en_in(!sleep_s2),
    .sel_in(conv_clock_select),
    .tick_out(tick)
  );

  // ========================================================================
  // Sequencer
  // ========================================================================
  // Zero acquisition skips to converting; an RC start passes through ST_RC_DELAY first
  always_comb begin
    if (rc_sel) begin
      launch_state = sar_adc_pkg::ST_RC_DELAY;
    end else if (acq_periods == 5'd0) begin
      launch_state = sar_adc_pkg::ST_CONVERT;
    end else begin
      launch_state = sar_adc_pkg::ST_ACQUIRE;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      sar_adc_pkg::ST_IDLE: begin
        if (go_set) begin
          next_state = launch_state;
        end
      end
      sar_adc_pkg::ST_RC_DELAY: begin
        // Leaves time for the processor to enter sleep
        if (delay_cnt == 3'(`INSTR_CYCLE_CLOCKS - 1)) begin
          next_state = (acq_periods == 5'd0) ? sar_adc_pkg::ST_CONVERT
                                          : sar_adc_pkg::ST_ACQUIRE;
        end
      end
      sar_adc_pkg::ST_ACQUIRE: begin
        if (tick && period_cnt == acq_periods - 5'd1) begin
          next_state = sar_adc_pkg::ST_CONVERT;
        end
      end
      sar_adc_pkg::ST_CONVERT: begin
        if (done_evt) begin
          next_state = sar_adc_pkg::ST_HOLDOFF;
        end
      end
      sar_adc_pkg::ST_HOLDOFF: begin
        // A start taken here waits out the recovery first
        if (tick && period_cnt == 5'(`HOLDOFF_PERIODS - 1)) begin
          next_state = go ? launch_state : sar_adc_pkg::ST_IDLE;
        end
      end
      default: next_state = sar_adc_pkg::ST_IDLE;
    endcase
    if (!module_on) begin
      next_state = sar_adc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      state <= sar_adc_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Period and delay counters restart on every state change
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN || state != next_state) begin
      period_cnt <= 5'd0;
      delay_cnt <= 3'd0;
    end else begin
      if (tick) begin
        period_cnt <= period_cnt + 5'd1;
      end
      if (state == sar_adc_pkg::ST_RC_DELAY) begin
        delay_cnt <= delay_cnt + 3'd1;
      end
    end
  end

  // Status bit: set by start, cleared at completion or power-down
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN || !module_on) begin
      go <= 1'b0;
    end else if (done_evt) begin
      go <= 1'b0;
    end else if (go_set) begin
      go <= 1'b1;
    end
  end

  // Done flag: hardware set wins over a simultaneous clear
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      conv_done_flag <= 1'b0;
    end else if (done_evt) begin
      conv_done_flag <= 1'b1;
    end else if (flag_clr) begin
      conv_done_flag <= 1'b0;
    end
  end

  // ========================================================================
  // Successive approximation
  // ========================================================================
  // Keep or drop the bit under trial, then try the next one down
  always_comb begin
    next_sar = sar;
    next_sar[bit_idx] = comp_s2;
    if (bit_idx != 4'd0) begin
      next_sar[bit_idx - 4'd1] = 1'b1;
    end
  end

  // First period settles the held sample; ten decisions follow
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      sar <= 10'h000;
      bit_idx <= 4'd9;
    end else if (state != sar_adc_pkg::ST_CONVERT &&
                 next_state == sar_adc_pkg::ST_CONVERT) begin
      sar <= 10'h200;
      bit_idx <= 4'd9;
    end else if (state == sar_adc_pkg::ST_CONVERT && tick && period_cnt != 5'd0) begin
      sar <= next_sar;
      if (bit_idx != 4'd0) begin
        bit_idx <= bit_idx - 4'd1;
      end
    end
  end

  // Result pair has no reset so its contents survive resets
  always_ff @(posedge CLOCK_IN) begin
    if (done_evt) begin
      if (justify_select) begin
        {result_upper, result_lower} <= {6'h00, next_sar};
      end else begin
        {result_upper, result_lower} <= {next_sar, 6'h00};
      end
    end
  end

  // ========================================================================
  // Pin and channel decode
  // ========================================================================
  // Digital count grows from input 12 downward
  always_comb begin
    analog_map = 13'h0000;
    for (int i = 0; i < `NUM_INPUTS; i++) begin
      if (pin_config_field < 4'h3) begin
        analog_map[i] = 1'b1;
      end else begin
        analog_map[i] = (i < (`NUM_INPUTS + 2 - int'(pin_config_field)));
      end
      if (!LARGE_PACKAGE && i >= 5 && i <= 7) begin
        analog_map[i] = 1'b0;
      end
    end
    chan_ok = (selector <= `LAST_CHANNEL) &&
              (LARGE_PACKAGE || selector < 4'h5 || selector > 4'h7);
  end

  // Analog side outputs, registered
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      SAMPLE_OUT <= 1'b0;
      CONVERTING_OUT <= 1'b0;
      CHANNEL_OUT <= 4'h0;
      CHANNEL_VALID_OUT <= 1'b0;
      ANALOG_PINS_OUT <= 13'h0000;
    end else begin
      SAMPLE_OUT <= module_on && next_state != sar_adc_pkg::ST_CONVERT;
      CONVERTING_OUT <= (next_state == sar_adc_pkg::ST_CONVERT);
      CHANNEL_OUT <= selector;
      CHANNEL_VALID_OUT <= chan_ok;
      ANALOG_PINS_OUT <= analog_map;
    end
  end

  assign DAC_CODE_OUT = sar;
  assign NEG_REF_EXT_OUT = neg_ref_select;
  assign POS_REF_EXT_OUT = pos_ref_select;
  assign MODULE_ON_OUT = module_on;
  assign DONE_FLAG_OUT = conv_done_flag;

endmodule

//--- tb/sar_adc_properties.sv
`timescale 1ns/10ps
module sar_adc_properties #(
  parameter int RC_DIV = 80 // RC period in clocks
) (
  input wire logic CLOCK_IN, // Clock
  input wire logic SYS_RST_IN, // Reset
  input wire sar_adc_pkg::apb_req_t APB_REQ_IN, // Bus request
  input wire logic APB_PREADY_OUT, // Ready
  input wire logic APB_PSLVERR_OUT, // Bus error
  input wire logic [9:0] DAC_CODE_OUT, // Trial code
  input wire logic SAMPLE_OUT, // Sampling
  input wire logic CONVERTING_OUT, // Converting
  input wire logic MODULE_ON_OUT, // Powered
  input wire logic DONE_FLAG_OUT // Done flag
);
  logic [11:0] run; // Conversion length so far
  // ======
  // Length counter, cleared whenever not converting
  always_ff @(posedge CLOCK_IN) begin
    run <= CONVERTING_OUT ? run + 12'h001 : 12'h000;
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_setup;
    APB_REQ_IN.psel && !APB_REQ_IN.penable;
  endsequence
  sequence s_end;
    $fell(CONVERTING_OUT) && MODULE_ON_OUT;
  endsequence
  property p_ready; s_setup |-> ##2 APB_PREADY_OUT; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_pulse; APB_PREADY_OUT |=> !APB_PREADY_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("ready stuck");
  property p_err; APB_PSLVERR_OUT |-> APB_PREADY_OUT; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_excl; SAMPLE_OUT |-> !CONVERTING_OUT; endproperty
  a_excl: assert property (p_excl) else $error("sampling while converting");
  property p_off; $fell(MODULE_ON_OUT) |-> ##2 !SAMPLE_OUT && !CONVERTING_OUT; endproperty
  a_off: assert property (p_off) else $error("still active when off");
  property p_msb; $rose(CONVERTING_OUT) |-> DAC_CODE_OUT == 10'h200; endproperty
  a_msb: assert property (p_msb) else $error("first trial wrong");
  // Longest conversion is eleven of the slower of the /64 and RC periods
  property p_len;
    s_end |-> run >= 12'd21 && run <= 12'(11 * (RC_DIV > 64 ? RC_DIV : 64) + 1);
  endproperty
  a_len: assert property (p_len) else $error("conversion length");
  property p_done; s_end |-> ##[0:2] DONE_FLAG_OUT; endproperty
  a_done: assert property (p_done) else $error("flag not set");
  property p_resume; s_end |-> ##[0:1] SAMPLE_OUT; endproperty
  a_resume: assert property (p_resume) else $error("no resampling");
endmodule

//--- tb/sar_adc_analog_model.sv
`timescale 1ns/10ps
module sar_adc_analog_model (
  input wire logic clk_in, // System clock
  input wire logic [9:0] level_in, // Input level as a code
  input wire logic sample_in, // Switch closed
  input wire logic hold_in, // Converting
  input wire logic [9:0] trial_in, // DAC trial
  output logic comp_out // Comparator
);
  logic [9:0] held = 10'h000; // Hold capacitor
  logic junk = 1'b0; // Toggles so an idle comparator is never trusted
  // Track the input only while the switch is closed
  always @(posedge clk_in) begin
    junk <= ~junk;
    if (sample_in) held <= level_in;
  end
  assign comp_out = hold_in ? (held >= trial_in) : junk;
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk, rst, fuse, sleep, comp, rdy, err, perr, conv, samp, vld, nref, pref, on, done;
  sar_adc_pkg::apb_req_t req; // Bus request
  logic [31:0] rdata, prd; // Read data
  logic [31:0] want; // Expected result pair
  logic [9:0] dac, level; // Trial and input level
  logic [7:0] hi; // Upper result byte
  logic [3:0] chan; // Selected input
  logic [12:0] pins; // Analog map
  int bad_count, cmp_count, cyc, n, t, run;
  int perv[8] = '{2, 8, 32, 4, 4, 16, 64, 4}; // Clocks per period, RC at 4
  int acqv[8] = '{0, 2, 4, 6, 8, 12, 16, 20}; // Acquisition periods
  sar_adc_control_unit #(.RC_DIV(4)) u_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .APB_REQ_IN(req),
    .APB_PRDATA_OUT(prd), .APB_PREADY_OUT(rdy), .APB_PSLVERR_OUT(err), .PORT_ANALOG_FUSE_IN(fuse),
    .SLEEP_IN(sleep), .COMP_IN(comp), .DAC_CODE_OUT(dac), .SAMPLE_OUT(samp), .CONVERTING_OUT(conv),
    .CHANNEL_OUT(chan), .CHANNEL_VALID_OUT(vld), .ANALOG_PINS_OUT(pins), .NEG_REF_EXT_OUT(nref),
    .POS_REF_EXT_OUT(pref), .MODULE_ON_OUT(on), .DONE_FLAG_OUT(done));
  sar_adc_analog_model u_ana (.clk_in(clk), .level_in(level), .sample_in(samp), .hold_in(conv),
    .trial_in(dac), .comp_out(comp));
  // ======
  // Clock, timeout and conversion length
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (conv === 1'b1) run <= run + 1;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer, held until ready is seen at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk) req.penable <= 1'b1;
    // No fixed latency assumed; the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdata = prd;
    perr = err;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ======
  // Main sequence
  initial begin
    rst = 1;
    fuse = 1;
    sleep = 0;
    level = 0;
    req = '0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    run = 0;
    repeat (16) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    check(32'(pins), 32'h1FFF);
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'(4 * i), 32'hFC);
      bus(0, 8'(4 * i), 0);
      check(rdata, i == 2 ? 32'hBC : 32'h3C);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1, 8'h04, (32'(i[1:0]) << 4) | 32'(i));
      bus(1, 8'h00, 32'(i) << 2);
      // Channel outputs are registered once more after the write lands
      @(posedge clk);
      check(32'(pins), 32'(13'h1FFF >> (i < 3 ? 0 : i - 2)));
      check(32'({nref, pref}), 32'(i[1:0]));
      check(32'({vld, chan}), 32'({i <= 12, 4'(i)}));
    end
    bus(1, 8'h00, 32'h2);
    bus(0, 8'h00, 0);
    check(rdata, 32'h0);
    bus(0, 8'h18, 0);
    check(32'(perr), 1);
    for (int i = 0; i < 8; i++) begin
      t = perv[i];
      level <= 10'h2A5 ^ 10'(i * 83);
      sleep <= i[1] & i[0];
      bus(1, 8'h08, (32'(i[0]) << 7) | (32'(i) << 3) | 32'(i));
      bus(1, 8'h00, 32'h1);
      run = 0;
      bus(1, 8'h00, 32'h3);
      n = 0;
      while (conv !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      n = n - acqv[i] * t;
      check(32'(n >= -2 && n <= t + 8), 1);
      bus(0, 8'h00, 0);
      check(32'(rdata[1]), 1);
      do bus(0, 8'h00, 0); while (rdata[1] === 1'b1 && cyc < 29000);
      check(32'(run >= 11 * t - 1 && run <= 11 * t + 1), 1);
      check(32'(done), 1);
      bus(0, 8'h0C, 0);
      hi = rdata[7:0];
      bus(0, 8'h10, 0);
      want = i[0] ? {22'h0, level} : {16'h0, level, 6'h0};
      if (i != 0) check({hi, rdata[7:0]}, want);
      bus(1, 8'h14, 32'h1);
      bus(0, 8'h14, 0);
      check(rdata, 32'h0);
      repeat (3 * t) @(posedge clk);
    end
    bus(1, 8'h08, 32'h06);
    bus(1, 8'h00, 32'h3);
    repeat (40) @(posedge clk);
    bus(1, 8'h00, 32'h0);
    repeat (2) @(posedge clk);
    check(32'(conv), 0);
    bus(1, 8'h00, 32'h3);
    repeat (20) @(posedge clk);
    rst <= 1;
    fuse <= 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    check(32'({pins, on, conv}), {17'h0, 13'h00FF, 2'b00});
    bus(0, 8'h08, 0);
    check(rdata, 32'h0);
    report_and_stop();
  end
endmodule
bind sar_adc_control_unit sar_adc_properties #(.RC_DIV(RC_DIV)) u_props (.CLOCK_IN, .SYS_RST_IN,
  .APB_REQ_IN, .APB_PREADY_OUT, .APB_PSLVERR_OUT, .DAC_CODE_OUT, .SAMPLE_OUT, .CONVERTING_OUT,
  .MODULE_ON_OUT, .DONE_FLAG_OUT);
